// *** logic/swc_mode_wdog.sv ***
// operating mode controller, serial registers and watchdog
// Operation
// - over protection threshold, enter overtemp from any mode but sleep and off
// - overtemp disables transceiver and regulators, holds reset pin low, keeps wake pending
// - warning sets status bit; event latched only when its enable is set
// - overtemp exits to reset on cooling, to off on battery loss
// - forced run keeps transceiver and regulators on, watchdog off
// - forced run enable presets to 1; cleared, device passes reset to standby
// - reset sources still act in forced run; transceiver stays on; returns forced
// - forced run serves reads only of status, identity and nonvolatile registers
// - nonvolatile configuration writable only while still in factory state
// - in low power modes receive output high, low once wake pending
// - normal mode receive output carries bus unless transceiver mode is 00
// - mode field bits 2:0 requests sleep, standby, normal; reads current mode
// - status bit 6 is warning, bit 5 set until first normal mode
// - cause field codes wake causes from sleep
// - cause field codes power-on, watchdog, external, overtemp, undervoltage, sleep faults
// - watchdog change in normal forces reset with cause 10000 and failure event
// - window setting behaves as timeout in standby, window only in normal
// - correct write to watchdog control triggers and restarts the counter
// - period field selects 8 to 4096 ms, default 128 ms
// - watchdog mode field bits 7:5 selects autonomous, timeout or window
// - effective watchdog state follows forced, devel, mode field and operating mode
// - startup threshold field loads runtime undervoltage threshold at start-up
// - sleep block bit set makes sleep requests ignored
// - window mode early trigger or overflow resets; late trigger restarts
// - timeout overflow sets failure flag; overflow with flag set resets
module swc_mode_wdog #(
	parameter logic [16:0] MS_CYCLES = 17'(swc_pkg::MS_CYCLES)
) (
	// clock, reset, enable
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       ce,
	// serial register port
	input  wire logic       spiSclk,
	input  wire logic       spiCsN,
	input  wire logic       spiMosi,
	output logic            spiMiso,
	// analog sense and wake inputs
	input  wire logic       overTemp,
	input  wire logic       tempWarn,
	input  wire logic       batPowerOff,
	input  wire logic       v1Undervolt,
	input  wire logic       resetPinIn,
	input  wire logic       busRxd,
	input  wire logic       busWake,
	input  wire logic       localWake,
	input  wire logic       diagWake,
	input  wire logic       frameErr,
	// loose control bits
	input  wire logic [1:0] transceiverModeSelect,
	input  wire logic       tempWarningEventEnable,
	input  wire logic       serialFailureEventEnable,
	input  wire logic       auxRegRequest,
	input  wire logic [2:0] eventClear,
	// outputs to pins and analog
	output logic            rxd,
	output logic            mainRegulator,
	output logic            auxRegulator,
	output logic            transceiverActive,
	output logic            resetPinOut,
	output logic            resetPinOeN,
	output logic [1:0]      runtimeUvThreshold,
	// events
	output logic            tempWarningEvent,
	output logic            serialFailureEvent,
	output logic            wdogFailureFlag
);
	// ==========================================
	// functions
	function automatic logic [12:0] periodMs(input logic [3:0] code);
		case (code)
			4'h8: periodMs = 13'h0008;
			4'h1: periodMs = 13'h0010;
			4'h2: periodMs = 13'h0020;
			4'hB: periodMs = 13'h0040;
			4'h4: periodMs = 13'h0080;
			4'hD: periodMs = 13'h0100;
			4'hE: periodMs = 13'h0400;
			4'h7: periodMs = 13'h1000;
			default: periodMs = 13'h0000;
		endcase
	endfunction : periodMs

	function automatic logic isWdMode(input logic [2:0] m);
		isWdMode = (m == swc_pkg::WDM_AUTO) || (m == swc_pkg::WDM_TIMEOUT) || (m == swc_pkg::WDM_WINDOW);
	endfunction : isWdMode

	// ==========================================
	// state
	swc_pkg::swc_mode_e mode, next_mode;
	swc_pkg::swc_wdog_e wdEff, wdEffQ;
	logic [4:0]  resetCause, next_cause;
	logic [7:0]  wdogCtrl, chipCfg;
	logic        nvFactory, firstNormalPending, tempWarnStatus, tempWarnQ, wakePending;
	logic        sclkQ, csQ, misoQ;
	logic [4:0]  bitCnt;
	logic [15:0] shIn;
	logic [7:0]  shOut;
	logic [16:0] msPre;
	logic [12:0] wdMs;
	logic [4:0]  rstMs;

	// ==========================================
	// serial frame decode
	wire logic       sclkRise = spiSclk & ~sclkQ & ~spiCsN;
	wire logic       sclkFall = ~spiSclk & sclkQ & ~spiCsN;
	wire logic       frameEnd = spiCsN & ~csQ;
	wire logic       spiOn    = (mode == swc_pkg::M_STANDBY) || (mode == swc_pkg::M_NORMAL) || (mode == swc_pkg::M_FORCED);
	wire logic       wrStb    = frameEnd && (bitCnt == swc_pkg::FRAME_BITS) && !shIn[swc_pkg::RO_BIT] && spiOn;
	wire logic [6:0] wrAddr   = shIn[15:9];
	wire logic [7:0] wrData   = shIn[7:0];
	wire logic       readLoad = sclkRise && (bitCnt == swc_pkg::ADDR_BITS);
	wire logic [6:0] rdSel    = shIn[6:0];

	// ==========================================
	// configuration fields
	wire logic       forcedRun  = chipCfg[swc_pkg::CFG_FORCED_BIT];
	wire logic       develMode  = chipCfg[swc_pkg::CFG_DEVEL_BIT];
	wire logic       sleepBlock = chipCfg[swc_pkg::CFG_SLEEP_BIT];
	wire logic [2:0] wdMode     = wdogCtrl[7:5];
	wire logic [12:0] wdPer     = periodMs(wdogCtrl[3:0]);
	wire logic       inNormal   = (mode == swc_pkg::M_NORMAL);
	wire logic       inStandby  = (mode == swc_pkg::M_STANDBY);
	wire logic       inSleep    = (mode == swc_pkg::M_SLEEP);

	// ==========================================
	// read mux
	logic [2:0] modeCode;
	always_comb begin
		case (mode)
			swc_pkg::M_NORMAL: modeCode = swc_pkg::OPM_NORMAL;
			swc_pkg::M_SLEEP:  modeCode = swc_pkg::OPM_SLEEP;
			default:           modeCode = swc_pkg::OPM_STANDBY;
		endcase
	end
	wire logic firstHalf = wdMs < (wdPer >> 1);
	wire logic [1:0] wdStat = (wdEff == swc_pkg::WD_OFF) ? 2'h0 : (firstHalf ? 2'h1 : 2'h2);
	// restricted set while forced run is active
	wire logic rdAllowed = (mode != swc_pkg::M_FORCED) || (rdSel == swc_pkg::A_MAIN_STAT) || (rdSel == swc_pkg::A_WDOG_STAT)
		|| (rdSel == swc_pkg::A_IDENT) || (rdSel == swc_pkg::A_NV_STAT) || (rdSel == swc_pkg::A_CHIP_CFG);
	logic [7:0] rdRaw;
	always_comb begin
		case (rdSel)
			swc_pkg::A_WDOG_CTRL: rdRaw = wdogCtrl & 8'hEF;
			swc_pkg::A_OP_MODE:   rdRaw = {5'h00, modeCode};
			swc_pkg::A_MAIN_STAT: rdRaw = {1'b0, tempWarnStatus, firstNormalPending, resetCause};
			swc_pkg::A_WDOG_STAT: rdRaw = {4'h0, mode == swc_pkg::M_FORCED, develMode, wdStat};
			swc_pkg::A_NV_STAT:   rdRaw = {7'h00, nvFactory};
			swc_pkg::A_CHIP_CFG:  rdRaw = chipCfg;
			swc_pkg::A_IDENT:     rdRaw = swc_pkg::IDENT_VALUE;
			default:              rdRaw = 8'h00;
		endcase
	end
	wire logic [7:0] rdData = rdAllowed ? rdRaw : 8'h00;

	// ==========================================
	// watchdog decode
	always_comb begin
		if (forcedRun || (wdMode == swc_pkg::WDM_AUTO && develMode)) begin
			wdEff = swc_pkg::WD_OFF;
		end else if (wdMode == swc_pkg::WDM_AUTO) begin
			wdEff = (inNormal || (inStandby && wakePending)) ? swc_pkg::WD_TIMEOUT : swc_pkg::WD_OFF;
		end else if (inNormal) begin
			wdEff = (wdMode == swc_pkg::WDM_WINDOW) ? swc_pkg::WD_WINDOW : swc_pkg::WD_TIMEOUT;
		end else if (inStandby || inSleep) begin
			wdEff = swc_pkg::WD_TIMEOUT;
		end else begin
			wdEff = swc_pkg::WD_OFF;
		end
	end
	wire logic msTick   = (msPre == MS_CYCLES - 17'h00001);
	wire logic wdOvf    = (wdEff != swc_pkg::WD_OFF) && msTick && (wdMs + 13'h0001 >= wdPer);
	wire logic wdTrig   = wrStb && (wrAddr == swc_pkg::A_WDOG_CTRL) && (inNormal || inStandby);
	wire logic wdChange = (wrData[7:5] != wdMode) || (wrData[3:0] != wdogCtrl[3:0]);
	wire logic wdIllegal = wdTrig && inNormal && wdChange;
	wire logic wdEarly  = wdTrig && (wdEff == swc_pkg::WD_WINDOW) && firstHalf;
	wire logic wdFailSet = wdOvf && (wdEff == swc_pkg::WD_TIMEOUT) && (!wdogFailureFlag || inSleep);
	wire logic wdReset  = (wdOvf && (wdEff == swc_pkg::WD_WINDOW || wdogFailureFlag)) || wdEarly;

	// ==========================================
	// mode requests
	wire logic modeWr   = wrStb && (wrAddr == swc_pkg::A_OP_MODE) && (inNormal || inStandby);
	wire logic sleepReq = modeWr && (wrData[2:0] == swc_pkg::OPM_SLEEP);
	wire logic badSleep = sleepReq && !sleepBlock && wakePending;
	wire logic anyWake  = busWake || localWake || diagWake || frameErr;
	wire logic rstDone  = (rstMs == 5'(swc_pkg::RESET_PULSE_MS));
	wire logic serialFailSet = serialFailureEventEnable && (wdIllegal || (sleepReq && sleepBlock) || badSleep);

	// ==========================================
	// mode machine
	always_comb begin
		next_mode  = mode;
		next_cause = resetCause;
		if (batPowerOff) begin
			next_mode = swc_pkg::M_OFF;
		end else begin
			case (mode)
				swc_pkg::M_OFF: begin
					next_mode  = swc_pkg::M_RESET;
					next_cause = swc_pkg::RC_POWER_ON;
				end
				swc_pkg::M_OVERTEMP: begin
					if (!overTemp) begin
						next_mode  = swc_pkg::M_RESET;
						next_cause = swc_pkg::RC_OT_EXIT;
					end
				end
				swc_pkg::M_SLEEP: begin
					if (anyWake || wdOvf) begin
						next_mode = swc_pkg::M_RESET;
					end
					if (busWake) begin
						next_cause = swc_pkg::RC_BUS_WAKE;
					end else if (localWake) begin
						next_cause = swc_pkg::RC_LOCAL_WAKE;
					end else if (diagWake) begin
						next_cause = swc_pkg::RC_DIAG_WAKE;
					end else if (frameErr) begin
						next_cause = swc_pkg::RC_FRAME_ERR;
					end else if (wdOvf) begin
						next_cause = swc_pkg::RC_SLEEP_WDOG;
					end
				end
				default: begin
					if (overTemp) begin
						next_mode = swc_pkg::M_OVERTEMP;
					end else if (v1Undervolt) begin
						next_mode  = swc_pkg::M_RESET;
						next_cause = swc_pkg::RC_UNDERVOLT;
					end else if (mode == swc_pkg::M_RESET) begin
						if (rstDone && resetPinIn) begin
							next_mode = forcedRun ? swc_pkg::M_FORCED : swc_pkg::M_STANDBY;
						end
					end else if (!resetPinIn) begin
						next_mode  = swc_pkg::M_RESET;
						next_cause = swc_pkg::RC_EXT_RESET;
					end else if (mode == swc_pkg::M_FORCED) begin
						if (!forcedRun) begin
							next_mode = swc_pkg::M_RESET;
						end
					end else if (wdIllegal) begin
						next_mode  = swc_pkg::M_RESET;
						next_cause = swc_pkg::RC_ILLEGAL_WD;
					end else if (wdReset) begin
						next_mode  = swc_pkg::M_RESET;
						next_cause = wdEarly ? swc_pkg::RC_EARLY_TRIG : swc_pkg::RC_WDOG_OVF;
					end else if (badSleep) begin
						next_mode  = swc_pkg::M_RESET;
						next_cause = swc_pkg::RC_ILLEGAL_SLP;
					end else if (modeWr) begin
						if (sleepReq && !sleepBlock) begin
							next_mode = swc_pkg::M_SLEEP;
						end else if (wrData[2:0] == swc_pkg::OPM_STANDBY) begin
							next_mode = swc_pkg::M_STANDBY;
						end else if (wrData[2:0] == swc_pkg::OPM_NORMAL && inStandby) begin
							next_mode = swc_pkg::M_NORMAL;
						end
					end
				end
			endcase
		end
	end

	// ==========================================
	// pin and supply outputs
	wire logic rxBus    = (mode == swc_pkg::M_FORCED) || (inNormal && transceiverModeSelect != 2'h0);
	wire logic trxOn    = rxBus || (mode == swc_pkg::M_RESET && forcedRun);
	wire logic mainOn   = (mode != swc_pkg::M_OFF) && !inSleep && (mode != swc_pkg::M_OVERTEMP);
	wire logic auxOn    = (mode == swc_pkg::M_FORCED) || (mainOn && auxRegRequest) || (inSleep && auxRegRequest);
	// reset pin released at pulse end so the pin can read back high
	wire logic rstDrive = (mode == swc_pkg::M_OFF) || inSleep || (mode == swc_pkg::M_OVERTEMP)
		|| (mode == swc_pkg::M_RESET && !rstDone);
	wire logic wakeSet  = (anyWake && !inNormal && (mode != swc_pkg::M_OFF)) || (inSleep && wdOvf);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rxd                <= 1'b1;
			mainRegulator      <= 1'b0;
			auxRegulator       <= 1'b0;
			transceiverActive  <= 1'b0;
			resetPinOut        <= 1'b0;
			resetPinOeN        <= 1'b0;
		end else if (ce) begin
			rxd                <= rxBus ? busRxd : !wakePending;
			mainRegulator      <= mainOn;
			auxRegulator       <= auxOn;
			transceiverActive  <= trxOn;
			resetPinOut        <= 1'b0;
			resetPinOeN        <= !rstDrive;
		end
	end

	// ==========================================
	// mode, status and configuration
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode               <= swc_pkg::M_OFF;
			resetCause         <= swc_pkg::RC_POWER_ON;
			wdogCtrl           <= swc_pkg::WDOG_CTRL_RESET;
			chipCfg            <= swc_pkg::CHIP_CFG_RESET;
			nvFactory          <= 1'b1;
			firstNormalPending <= 1'b1;
			runtimeUvThreshold <= 2'h0;
			tempWarnStatus     <= 1'b0;
			tempWarnQ          <= 1'b0;
			wakePending        <= 1'b0;
		end else if (ce) begin
			mode               <= next_mode;
			resetCause         <= next_cause;
			tempWarnStatus     <= tempWarn;
			tempWarnQ          <= tempWarn;
			if (wdTrig && inStandby && isWdMode(wrData[7:5]) && periodMs(wrData[3:0]) != 13'h0000) begin
				wdogCtrl <= wrData & 8'hEF;
			end else if (next_mode == swc_pkg::M_RESET && mode != swc_pkg::M_RESET && develMode) begin
				wdogCtrl <= {swc_pkg::WDM_AUTO, wdogCtrl[4:0]};
			end
			if (wrStb && wrAddr == swc_pkg::A_CHIP_CFG && nvFactory) begin
				chipCfg   <= wrData & swc_pkg::CHIP_CFG_MASK;
				nvFactory <= 1'b0;
			end
			if (mode == swc_pkg::M_OFF) begin
				firstNormalPending <= 1'b1;
				runtimeUvThreshold <= chipCfg[5:4];
			end else if (inNormal) begin
				firstNormalPending <= 1'b0;
			end
			if (wakeSet) begin
				wakePending <= 1'b1;
			end else if (next_mode == swc_pkg::M_NORMAL) begin
				wakePending <= 1'b0;
			end
		end
	end

	// ==========================================
	// events: set wins over clear
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tempWarningEvent   <= 1'b0;
			serialFailureEvent <= 1'b0;
			wdogFailureFlag    <= 1'b0;
		end else if (ce) begin
			tempWarningEvent   <= (tempWarn && !tempWarnQ && tempWarningEventEnable) || (tempWarningEvent && !eventClear[0]);
			serialFailureEvent <= serialFailSet || (serialFailureEvent && !eventClear[1]);
			wdogFailureFlag    <= wdFailSet || (wdogFailureFlag && !eventClear[2]);
		end
	end

	// ==========================================
	// timers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			msPre  <= 17'h00000;
			wdMs   <= 13'h0000;
			wdEffQ <= swc_pkg::WD_OFF;
			rstMs  <= 5'h00;
		end else if (ce) begin
			msPre  <= msTick ? 17'h00000 : msPre + 17'h00001;
			wdEffQ <= wdEff;
			if (wdEff == swc_pkg::WD_OFF || wdEff != wdEffQ || wdTrig || wdOvf) begin
				wdMs <= 13'h0000;
			end else if (msTick) begin
				wdMs <= wdMs + 13'h0001;
			end
			if (mode != swc_pkg::M_RESET || v1Undervolt) begin
				rstMs <= 5'h00;
			end else if (msTick && !rstDone) begin
				rstMs <= rstMs + 5'h01;
			end
		end
	end

	// ==========================================
	// serial shifter
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sclkQ   <= 1'b0;
			csQ     <= 1'b1;
			bitCnt  <= 5'h00;
			shIn    <= 16'h0000;
			shOut   <= 8'h00;
			misoQ   <= 1'b0;
		end else if (ce) begin
			sclkQ <= spiSclk;
			csQ   <= spiCsN;
			if (spiCsN) begin
				bitCnt <= 5'h00;
				misoQ  <= 1'b0;
			end else if (sclkRise) begin
				shIn   <= {shIn[14:0], spiMosi};
				bitCnt <= (bitCnt == swc_pkg::FRAME_BITS) ? bitCnt : bitCnt + 5'h01;
				if (readLoad) begin
					shOut <= rdData;
				end
			end else if (sclkFall && bitCnt > swc_pkg::ADDR_BITS) begin
				misoQ <= shOut[7];
				shOut <= {shOut[6:0], 1'b0};
			end
		end
	end
	assign spiMiso = misoQ;

	// ==========================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire logic calm = ce && !batPowerOff;

	a_otp_entry: assert property (calm && overTemp && (inNormal || inStandby) |=> mode == swc_pkg::M_OVERTEMP)
		else $error("overtemp not entered");
	a_otp_outputs: assert property (ce && mode == swc_pkg::M_OVERTEMP |=>
		!mainRegulator && !auxRegulator && !transceiverActive && !resetPinOeN)
		else $error("overtemp outputs wrong");
	a_warn_event: assert property (ce && $rose(tempWarn) && tempWarningEventEnable |=> tempWarningEvent)
		else $error("warning event lost");
	a_otp_exit: assert property (calm && mode == swc_pkg::M_OVERTEMP && !overTemp |=>
		mode == swc_pkg::M_RESET && resetCause == swc_pkg::RC_OT_EXIT)
		else $error("overtemp exit wrong");
	a_forced_wdog: assert property (mode == swc_pkg::M_FORCED |-> wdEff == swc_pkg::WD_OFF && wdMs == 13'h0000)
		else $error("watchdog runs in forced run");
	a_forced_read: assert property (mode == swc_pkg::M_FORCED && rdSel == swc_pkg::A_WDOG_CTRL |-> rdData == 8'h00)
		else $error("forced run read not blocked");
	a_illegal_wd: assert property (calm && !overTemp && !v1Undervolt && resetPinIn && wdIllegal |=>
		mode == swc_pkg::M_RESET && resetCause == swc_pkg::RC_ILLEGAL_WD)
		else $error("illegal watchdog change missed");
	a_window_std: assert property (inStandby && !forcedRun && wdMode == swc_pkg::WDM_WINDOW |->
		wdEff == swc_pkg::WD_TIMEOUT)
		else $error("window active in standby");
	a_sleep_blk: assert property (calm && inStandby && sleepReq && sleepBlock |=> mode != swc_pkg::M_SLEEP)
		else $error("blocked sleep entered");

	c_forced_reset: cover property (mode == swc_pkg::M_FORCED ##1 mode == swc_pkg::M_RESET);
	c_normal_entry: cover property (inStandby ##1 inNormal);
	c_sleep_entry: cover property (inStandby ##1 inSleep);
	c_wdog_reset: cover property (inNormal && wdReset);
endmodule : swc_mode_wdog

// *** shared/swc_pkg.sv ***
// constants and types shared by the mode and watchdog controller
package swc_pkg;
	// ==========================================
	// timing
	localparam int CLK_HZ         = 125_000_000;
	localparam int MS_PER_S       = 1000;
	localparam int MS_CYCLES      = CLK_HZ / MS_PER_S;
	localparam int RESET_PULSE_MS = 20;
	// ==========================================
	// register addresses (7-bit serial address)
	localparam logic [6:0] A_WDOG_CTRL = 7'h00;
	localparam logic [6:0] A_OP_MODE   = 7'h01;
	localparam logic [6:0] A_MAIN_STAT = 7'h03;
	localparam logic [6:0] A_WDOG_STAT = 7'h05;
	localparam logic [6:0] A_NV_STAT   = 7'h70;
	localparam logic [6:0] A_CHIP_CFG  = 7'h74;
	localparam logic [6:0] A_IDENT     = 7'h7E;
	// arbitrary identification value
	localparam logic [7:0] IDENT_VALUE = 8'h5A;
	// ==========================================
	// serial frame: addr[15:9], read-only[8], data[7:0]
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] ADDR_BITS  = 5'h07;
	localparam int         RO_BIT     = 8;
	// ==========================================
	// field codes and positions
	localparam logic [2:0] OPM_SLEEP   = 3'h1;
	localparam logic [2:0] OPM_STANDBY = 3'h4;
	localparam logic [2:0] OPM_NORMAL  = 3'h7;
	localparam logic [2:0] WDM_AUTO    = 3'h1;
	localparam logic [2:0] WDM_TIMEOUT = 3'h2;
	localparam logic [2:0] WDM_WINDOW  = 3'h4;
	localparam logic [7:0] WDOG_CTRL_RESET = 8'h44;
	localparam logic [7:0] CHIP_CFG_RESET  = 8'h08;
	localparam logic [7:0] CHIP_CFG_MASK   = 8'h3D;
	localparam int CFG_SLEEP_BIT  = 0;
	localparam int CFG_DEVEL_BIT  = 2;
	localparam int CFG_FORCED_BIT = 3;
	// ==========================================
	// reset cause codes
	localparam logic [4:0] RC_POWER_ON    = 5'h00;
	localparam logic [4:0] RC_BUS_WAKE    = 5'h01;
	localparam logic [4:0] RC_LOCAL_WAKE  = 5'h04;
	localparam logic [4:0] RC_SLEEP_WDOG  = 5'h0C;
	localparam logic [4:0] RC_DIAG_WAKE   = 5'h0D;
	localparam logic [4:0] RC_EARLY_TRIG  = 5'h0E;
	localparam logic [4:0] RC_WDOG_OVF    = 5'h0F;
	localparam logic [4:0] RC_ILLEGAL_WD  = 5'h10;
	localparam logic [4:0] RC_EXT_RESET   = 5'h11;
	localparam logic [4:0] RC_OT_EXIT     = 5'h12;
	localparam logic [4:0] RC_UNDERVOLT   = 5'h13;
	localparam logic [4:0] RC_ILLEGAL_SLP = 5'h14;
	localparam logic [4:0] RC_FRAME_ERR   = 5'h16;
	// ==========================================
	// types
	typedef enum logic [2:0] {M_OFF, M_RESET, M_STANDBY, M_NORMAL, M_SLEEP, M_FORCED, M_OVERTEMP} swc_mode_e;
	typedef enum logic [1:0] {WD_OFF, WD_TIMEOUT, WD_WINDOW} swc_wdog_e;
endpackage : swc_pkg

// *** testbench/swc_host_model.sv ***
// host microcontroller model: serial frames and reset pin wiring
module swc_host_model (
	// clock
	input  wire logic ref_clk,
	// serial port
	output logic      spiSclk,
	output logic      spiCsN,
	output logic      spiMosi,
	input  wire logic spiMiso,
	// reset pin
	input  wire logic resetPinOut,
	input  wire logic resetPinOeN,
	output logic      resetPinIn
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// pin wiring
	// pull-up wins once the device lets go
	assign resetPinIn = resetPinOeN ? 1'b1 : resetPinOut;
	initial begin
		spiSclk = 1'b0;
		spiCsN  = 1'b1;
		spiMosi = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : hold
	// ==========================================
	// frames
	// msb first, three cycles a level; miso sampled before each of the eight data bit rises
	task automatic frame(input logic [6:0] a, input logic ro, input logic [7:0] d, output logic [7:0] q);
		logic [15:0] w;
		w = {a, ro, d};
		q = 8'h00;
		spiCsN = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spiMosi = w[i];
			hold(3);
			if (i < 8)
				q = {q[6:0], spiMiso};
			spiSclk = 1'b1;
			hold(3);
			spiSclk = 1'b0;
		end
		hold(3);
		spiCsN = 1'b1;
		// released line does not keep its last value
		spiMosi = ~spiMosi;
		hold(3);
	endtask : frame
endmodule : swc_host_model

// *** testbench/swc_mode_wdog_test.sv ***
// self-checking bench for the mode and watchdog controller
module swc_mode_wdog_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 0, resetn = 0, overTemp = 0, tempWarn = 0, busRxd = 1, busWake = 0, v1Undervolt = 0;
	logic tempWarningEventEnable = 1, serialFailureEventEnable = 1, auxRegRequest = 0, ce = 1;
	logic [1:0] transceiverModeSelect = 2'h1;
	logic [2:0] eventClear = 3'h0;
	logic spiSclk, spiCsN, spiMosi, spiMiso, resetPinIn, rxd, mainRegulator, auxRegulator, transceiverActive;
	logic resetPinOut, resetPinOeN, tempWarningEvent, serialFailureEvent, wdogFailureFlag;
	logic [1:0] runtimeUvThreshold;
	logic [7:0] rd;
	int n_mismatch = 0, checked = 0, cyc = 0;
	swc_mode_wdog #(.MS_CYCLES(17'h14)) uut (.ref_clk, .resetn, .ce, .spiSclk, .spiCsN, .spiMosi,
		.spiMiso, .overTemp, .tempWarn, .batPowerOff(1'b0), .v1Undervolt, .resetPinIn, .busRxd, .busWake,
		.localWake(1'b0), .diagWake(1'b0), .frameErr(1'b0), .transceiverModeSelect, .tempWarningEventEnable,
		.serialFailureEventEnable, .auxRegRequest, .eventClear, .rxd, .mainRegulator, .auxRegulator,
		.transceiverActive, .resetPinOut, .resetPinOeN, .runtimeUvThreshold, .tempWarningEvent,
		.serialFailureEvent, .wdogFailureFlag);
	swc_host_model host (.ref_clk, .spiSclk, .spiCsN, .spiMosi, .spiMiso, .resetPinOut, .resetPinOeN,
		.resetPinIn);
	always #4 ref_clk = ~ref_clk;
	// ==========================================
	// helpers
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic rr(input logic [6:0] a, input logic [7:0] exp);
		host.frame(a, 1'b1, 8'h00, rd);
		cmp(rd, exp);
	endtask : rr
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.frame(a, 1'b0, d, rd);
	endtask : wr
	// reset pulse is 20 ms of 20 cycles; bounded wait for release
	task automatic waitRelease();
		host.hold(4);
		for (int i = 0; i < 2000 && resetPinOeN !== 1'b1; i++)
			host.hold(1);
		host.hold(4);
	endtask : waitRelease
	// ==========================================
	// scenarios
	task automatic testForced();
		cmp(transceiverActive, 8'h01);
		cmp(mainRegulator, 8'h01);
		cmp(runtimeUvThreshold, 8'h00);
		// enable low freezes the receive path
		ce = 0;
		busRxd = 0;
		host.hold(3);
		cmp(rxd, 8'h01);
		ce = 1;
		host.hold(3);
		cmp(rxd, 8'h00);
		busRxd = 1;
		rr(7'h03, 8'h20);
		rr(7'h01, 8'h00);
		rr(7'h74, 8'h08);
		$display("forced run test done");
	endtask : testForced
	task automatic testLeaveForced();
		wr(7'h74, 8'h01);
		waitRelease();
		cmp(transceiverActive, 8'h00);
		cmp(rxd, 8'h01);
		rr(7'h01, 8'h04);
		rr(7'h70, 8'h00);
		wr(7'h74, 8'h08);
		rr(7'h74, 8'h01);
		busWake = 1;
		host.hold(1);
		busWake = 0;
		host.hold(3);
		cmp(rxd, 8'h00);
		$display("leave forced test done");
	endtask : testLeaveForced
	task automatic testOvertemp();
		auxRegRequest = 1;
		host.hold(3);
		cmp(auxRegulator, 8'h01);
		overTemp = 1;
		tempWarn = 1;
		host.hold(4);
		cmp(mainRegulator, 8'h00);
		cmp(auxRegulator, 8'h00);
		cmp(resetPinOeN, 8'h00);
		cmp(rxd, 8'h00);
		cmp(tempWarningEvent, 8'h01);
		overTemp = 0;
		waitRelease();
		rr(7'h03, 8'h72);
		tempWarn = 0;
		eventClear = 3'h1;
		host.hold(1);
		eventClear = 3'h0;
		cmp(tempWarningEvent, 8'h00);
		$display("overtemp test done");
	endtask : testOvertemp
	task automatic testNormal();
		wr(7'h01, 8'h07);
		host.hold(3);
		cmp(transceiverActive, 8'h01);
		busRxd = 0;
		host.hold(3);
		cmp(rxd, 8'h00);
		transceiverModeSelect = 2'h0;
		host.hold(3);
		cmp(rxd, 8'h01);
		busRxd = 1;
		transceiverModeSelect = 2'h1;
		rr(7'h03, 8'h12);
		// period change in normal is refused by a reset
		wr(7'h00, 8'h48);
		waitRelease();
		cmp(serialFailureEvent, 8'h01);
		rr(7'h03, 8'h10);
		$display("normal test done");
	endtask : testNormal
	task automatic testStandby();
		// blocked sleep request raises the failure event only when enabled
		eventClear = 3'h2;
		serialFailureEventEnable = 0;
		host.hold(1);
		eventClear = 3'h0;
		wr(7'h01, 8'h01);
		cmp(serialFailureEvent, 8'h00);
		serialFailureEventEnable = 1;
		wr(7'h01, 8'h01);
		cmp(serialFailureEvent, 8'h01);
		rr(7'h01, 8'h04);
		v1Undervolt = 1;
		host.hold(30);
		cmp(resetPinOeN, 8'h00);
		v1Undervolt = 0;
		waitRelease();
		rr(7'h03, 8'h13);
		// unserviced timeout watchdog: first overflow flags, second resets
		for (int i = 0; i < 3000 && wdogFailureFlag !== 1'b1; i++)
			host.hold(1);
		cmp(wdogFailureFlag, 8'h01);
		cmp(resetPinOeN, 8'h01);
		for (int i = 0; i < 3000 && resetPinOeN !== 1'b0; i++)
			host.hold(1);
		waitRelease();
		rr(7'h03, 8'h0F);
		$display("standby test done");
	endtask : testStandby
	initial begin
		repeat (4) @(posedge ref_clk);
		#1 resetn = 1;
		waitRelease();
		testForced();
		testLeaveForced();
		testOvertemp();
		testNormal();
		testStandby();
		close_out();
	end
endmodule : swc_mode_wdog_test
